// File: ctinit_top.sv
// Counter and look-up table clearing block with its command register
`timescale 1ns/10ps
`default_nettype none
`include "ctinit_cfg.svh"
module ctinit_top (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Register port
    input wire logic [15:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    // Reset state of the main circuitry
    input wire logic main_held_i,
    // Counter memory write port (data is always zero)
    output logic cnt_we_o,
    output logic [15:0] cnt_addr_o,
    // External SRAM write port (data is always zero)
    output logic sram_we_o,
    output logic [15:0] sram_addr_o,
    // Remaining configuration bits of main_config_two
    output logic [13:0] cfg_bits_o
);
    import ctinit_pkg::*;

    //------------------------------------------------------------
    // Helpers
    //------------------------------------------------------------
    function automatic logic [15:0] range_first(input logic [1:0] idx);
        unique case (idx)
            2'h0: range_first = `CTINIT_RX_FIRST;
            2'h1: range_first = `CTINIT_TX_FIRST;
            default: range_first = `CTINIT_DROP_FIRST;
        endcase
    endfunction

    function automatic logic [15:0] range_last(input logic [1:0] idx);
        unique case (idx)
            2'h0: range_last = `CTINIT_RX_LAST;
            2'h1: range_last = `CTINIT_TX_LAST;
            default: range_last = `CTINIT_DROP_LAST;
        endcase
    endfunction

    function automatic logic [15:0] sram_last(input logic [2:0] code);
        logic [16:0] n;
        n = `CTINIT_SRAM_BASE << code;
        // Every code from the top one up means the whole table
        if (code >= `CTINIT_SRAM_MAX_CODE) begin
            sram_last = `CTINIT_SRAM_FULL;
        end else begin
            sram_last = 16'(n - 17'h00001);
        end
    endfunction

    // Register address decode, shared by the write and read paths
    function automatic logic hit_mc2(input logic [15:0] addr);
        hit_mc2 = (addr == `CTINIT_ADDR_MC2);
    endfunction

    function automatic logic hit_msz(input logic [15:0] addr);
        hit_msz = (addr == `CTINIT_ADDR_MSZ);
    endfunction

    //------------------------------------------------------------
    // State
    //------------------------------------------------------------
    ctinit_top_s s_ff;
    ctinit_top_s nxt_s;
    logic cnt_start;
    logic lut_start;
    logic cnt_done;
    logic lut_done;
    logic cnt_busy;
    logic lut_busy;
    logic [15:0] mc2_view;
    logic mc2_wr;
    logic msz_wr;
    logic mc2_rd;
    logic msz_rd;

    //------------------------------------------------------------
    // Register decode
    //------------------------------------------------------------
    // Strobes are ignored while the enable is low, since no state moves
    assign mc2_wr = wr_i && hit_mc2(addr_i);
    assign msz_wr = wr_i && hit_msz(addr_i);
    assign mc2_rd = rd_i && hit_mc2(addr_i);
    assign msz_rd = rd_i && hit_msz(addr_i);

    // Bits 15 and 14 read back the live command flags
    assign mc2_view = {s_ff.lut_cmd, s_ff.cnt_cmd, s_ff.cfg};
    assign cnt_start = (s_ff.st == CT_LOAD);
    // The wipe walker starts once per command
    assign lut_start = s_ff.lut_cmd && !s_ff.lut_run;

    //------------------------------------------------------------
    // Walkers
    //------------------------------------------------------------
    // Only counter ranges are walked; look-up record counters are not
    ctinit_walk u_cnt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .start_i(cnt_start),
        .adv_i(main_held_i),
        .first_i(range_first(s_ff.idx)),
        .last_i(range_last(s_ff.idx)),
        .step_i(`CTINIT_CNT_STEP),
        .we_o(cnt_we_o),
        .addr_o(cnt_addr_o),
        .busy_o(cnt_busy),
        .done_o(cnt_done)
    );

    // Extent follows the memory-size register
    ctinit_walk u_lut (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .start_i(lut_start),
        .adv_i(main_held_i),
        .first_i(16'h0000),
        .last_i(sram_last(s_ff.msz)),
        .step_i(`CTINIT_LUT_STEP),
        .we_o(sram_we_o),
        .addr_o(sram_addr_o),
        .busy_o(lut_busy),
        .done_o(lut_done)
    );

    //------------------------------------------------------------
    // Next state
    //------------------------------------------------------------
    always_comb begin
        nxt_s = s_ff;
        // Counter clear sequence over the three ranges
        unique case (s_ff.st)
            CT_IDLE: begin
                if (s_ff.cnt_cmd && !cnt_busy) begin
                    nxt_s.idx = 2'h0;
                    nxt_s.st = CT_LOAD;
                end
            end
            CT_LOAD: begin
                // One cycle for the walker to latch the next range bounds
                nxt_s.st = CT_RUN;
            end
            CT_RUN: begin
                if (cnt_done) begin
                    if (s_ff.idx == `CTINIT_LAST_RANGE) begin
                        nxt_s.cnt_cmd = 1'b0;
                        nxt_s.st = CT_IDLE;
                    end else begin
                        nxt_s.idx = s_ff.idx + 2'h1;
                        nxt_s.st = CT_LOAD;
                    end
                end
            end
            default: begin
                nxt_s.st = CT_IDLE;
            end
        endcase
        // Table wipe
        if (lut_start) begin
            nxt_s.lut_run = 1'b1;
        end
        if (lut_done) begin
            nxt_s.lut_cmd = 1'b0;
            nxt_s.lut_run = 1'b0;
        end
        // Register writes; a written one beats the hardware clear
        if (mc2_wr) begin
            nxt_s.cfg = wdata_i[13:0];
            if (wdata_i[`CTINIT_BIT_CNT]) begin
                nxt_s.cnt_cmd = 1'b1;
            end
            if (wdata_i[`CTINIT_BIT_LUT]) begin
                nxt_s.lut_cmd = 1'b1;
            end
        end
        if (msz_wr) begin
            nxt_s.msz = wdata_i[`CTINIT_MSZ_MSB:0];
        end
        // Read data, valid in the cycle after the strobe
        nxt_s.rdata = 16'h0000;
        if (mc2_rd) begin
            nxt_s.rdata = mc2_view;
        end else if (msz_rd) begin
            nxt_s.rdata = {13'h0, s_ff.msz};
        end
    end

    //------------------------------------------------------------
    // State register
    //------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            // Command flags drop, so a reset abandons any clear in progress
            s_ff.st <= CT_IDLE;
            s_ff.idx <= 2'h0;
            s_ff.cnt_cmd <= 1'b0;
            s_ff.lut_cmd <= 1'b0;
            s_ff.lut_run <= 1'b0;
            s_ff.cfg <= `CTINIT_MC2_RESET;
            s_ff.msz <= `CTINIT_MSZ_RESET;
            s_ff.rdata <= 16'h0000;
        end else if (ce_i) begin
            s_ff <= nxt_s;
        end
    end

    //------------------------------------------------------------
    // Outputs
    //------------------------------------------------------------
    assign rdata_o = s_ff.rdata;
    assign cfg_bits_o = s_ff.cfg;
endmodule // ctinit_top
`default_nettype wire

// File: ctinit_cfg.svh
// Constants for the counter and look-up table clearing block
//------------------------------------------------------------
//------------------------------------------------------------
`ifndef CTINIT_CFG_SVH
`define CTINIT_CFG_SVH

//------------------------------------------------------------
// Register map
//------------------------------------------------------------
`define CTINIT_ADDR_MC2 16'h0112
`define CTINIT_ADDR_MSZ 16'h0100
`define CTINIT_MC2_RESET 14'h1000
`define CTINIT_MSZ_RESET 3'h0
`define CTINIT_BIT_CNT 14
`define CTINIT_BIT_LUT 15
`define CTINIT_MSZ_MSB 2

//------------------------------------------------------------
// Counter ranges, cleared one 16-bit word at a time
//------------------------------------------------------------
`define CTINIT_RX_FIRST 16'h4000
`define CTINIT_RX_LAST 16'h40fe
`define CTINIT_TX_FIRST 16'h0600
`define CTINIT_TX_LAST 16'h06fe
`define CTINIT_DROP_FIRST 16'h3000
`define CTINIT_DROP_LAST 16'h31fe
`define CTINIT_CNT_STEP 16'h0002
`define CTINIT_LUT_STEP 16'h0001
`define CTINIT_LAST_RANGE 2'h2

//------------------------------------------------------------
// SRAM sizing: entries = 1K << code, code 6 and up is 64K
//------------------------------------------------------------
`define CTINIT_SRAM_BASE 17'h00400
`define CTINIT_SRAM_MAX_CODE 3'h6
`define CTINIT_SRAM_FULL 16'hffff

`endif

// File: ctinit_pkg.sv
// Types shared by the clearing block
`default_nettype none
package ctinit_pkg;
    typedef enum logic [2:0] {
        CT_IDLE = 3'b001,
        CT_LOAD = 3'b010,
        CT_RUN  = 3'b100
    } ctinit_state_e;

    typedef struct packed {
        logic        busy;
        logic        we;
        logic        done;
        logic [15:0] cur;
        logic [15:0] wr_addr;
        logic [15:0] last;
        logic [15:0] step;
    } ctinit_walk_s;

    typedef struct packed {
        ctinit_state_e st;
        logic [1:0]    idx;
        logic          cnt_cmd;
        logic          lut_cmd;
        logic          lut_run;
        logic [13:0]   cfg;
        logic [2:0]    msz;
        logic [15:0]   rdata;
    } ctinit_top_s;
endpackage
`default_nettype wire

// File: ctinit_walk.sv
// Address walker that zeroes one memory range location by location
`timescale 1ns/10ps
`default_nettype none
module ctinit_walk (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Control
    input wire logic start_i,
    input wire logic adv_i,
    input wire logic [15:0] first_i,
    input wire logic [15:0] last_i,
    input wire logic [15:0] step_i,
    // Write port and status
    output logic we_o,
    output logic [15:0] addr_o,
    output logic busy_o,
    output logic done_o
);
    import ctinit_pkg::*;

    ctinit_walk_s s_ff;
    ctinit_walk_s nxt_s;

    always_comb begin
        nxt_s = s_ff;
        nxt_s.we = 1'b0;
        nxt_s.done = 1'b0;
        if (start_i) begin
            nxt_s.busy = 1'b1;
            nxt_s.cur = first_i;
            nxt_s.last = last_i;
            nxt_s.step = step_i;
        end else if (s_ff.busy && adv_i) begin
            // One zero write per cycle until the last location
            nxt_s.we = 1'b1;
            nxt_s.wr_addr = s_ff.cur;
            if (s_ff.cur == s_ff.last) begin
                nxt_s.busy = 1'b0;
                nxt_s.done = 1'b1;
            end else begin
                nxt_s.cur = s_ff.cur + s_ff.step;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_ff <= '0;
        end else if (ce_i) begin
            s_ff <= nxt_s;
        end
    end

    assign we_o = s_ff.we;
    assign addr_o = s_ff.wr_addr;
    assign busy_o = s_ff.busy;
    assign done_o = s_ff.done;
endmodule // ctinit_walk
`default_nettype wire

// File: ctinit_zmem.sv
// Zeroing memory model that tallies the writes it receives
`timescale 1ns/10ps
`default_nettype none
module ctinit_zmem (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Write port, data always zero
    input wire logic we_i,
    input wire logic [15:0] addr_i,
    // Tally and last address written
    output logic [16:0] cnt_o,
    output logic [15:0] last_o
);
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_o <= 17'h0;
            last_o <= 16'h0;
        end else if (we_i) begin
            cnt_o <= cnt_o + 17'h1;
            last_o <= addr_i;
        end
    end
endmodule // ctinit_zmem
`default_nettype wire

// File: ctinit_asserts.sv
// Port assertions for the clearing block
`timescale 1ns/10ps
`default_nettype none
module ctinit_asserts (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Register port
    input wire logic [15:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [15:0] rdata_o,
    // Memory side
    input wire logic main_held_i,
    input wire logic cnt_we_o,
    input wire logic [15:0] cnt_addr_o,
    input wire logic sram_we_o,
    input wire logic [15:0] sram_addr_o,
    input wire logic [13:0] cfg_bits_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    cnt_start_a: assert property (wr_i && addr_i == 16'h0112 && wdata_i[14] && main_held_i
        |-> ##[1:5] cnt_we_o) else $error("counter clear did not start");
    sram_start_a: assert property (wr_i && addr_i == 16'h0112 && wdata_i[15] && main_held_i
        |-> ##[1:5] sram_we_o) else $error("table wipe did not start");
    cnt_range_a: assert property (cnt_we_o |-> !cnt_addr_o[0] && cnt_addr_o inside
        {[16'h4000:16'h40fe], [16'h0600:16'h06fe], [16'h3000:16'h31fe]}) else $error("bad counter");
    cnt_step_a: assert property (cnt_we_o ##1 cnt_we_o |-> cnt_addr_o == $past(cnt_addr_o) + 16'h2)
        else $error("counter step wrong");
    sram_step_a: assert property (sram_we_o ##1 sram_we_o |-> $changed(sram_addr_o)
        && sram_addr_o == $past(sram_addr_o) + 16'h1) else $error("sram step wrong");
    held_pause_a: assert property (!main_held_i [*2] |-> !cnt_we_o && !sram_we_o)
        else $error("clear ran while main not held");
    busy_read_a: assert property (cnt_we_o && cnt_addr_o != 16'h31fe && rd_i && addr_i == 16'h0112
        |=> rdata_o[14]) else $error("counter bit dropped early");
    lut_busy_a: assert property (sram_we_o && sram_addr_o[9:0] != 10'h3ff && rd_i
        && addr_i == 16'h0112 |=> rdata_o[15]) else $error("table bit dropped early");
    cover property (cnt_we_o && cnt_addr_o == 16'h31fe);
    cover property (sram_we_o && sram_addr_o == 16'hffff);
    cover property (cnt_we_o && sram_we_o);
endmodule // ctinit_asserts
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the clearing block
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import ctinit_pkg::*;
    logic clk_i = 0, rst_i = 1, ce_i = 1, wr_i = 0, rd_i = 0, main_held_i = 1;
    logic [15:0] addr_i = 0, wdata_i = 0, rdata_o, cnt_addr_o, sram_addr_o, d, ca, sa;
    logic [13:0] cfg_bits_o;
    logic cnt_we_o, sram_we_o;
    logic [16:0] cn, sn, c0, s0;
    int bad_count = 0, check_count = 0;
    always #12.5 clk_i = ~clk_i;
    ctinit_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .main_held_i(main_held_i),
        .cnt_we_o(cnt_we_o), .cnt_addr_o(cnt_addr_o), .sram_we_o(sram_we_o),
        .sram_addr_o(sram_addr_o), .cfg_bits_o(cfg_bits_o));
    ctinit_zmem u_cmem (.clk_i(clk_i), .rst_i(rst_i), .we_i(cnt_we_o), .addr_i(cnt_addr_o),
        .cnt_o(cn), .last_o(ca));
    ctinit_zmem u_smem (.clk_i(clk_i), .rst_i(rst_i), .we_i(sram_we_o), .addr_i(sram_addr_o),
        .cnt_o(sn), .last_o(sa));
    task automatic close_out();
        if (bad_count == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [16:0] seen, input logic [16:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        @(posedge clk_i);
        wr_i <= 1;
        addr_i <= a;
        wdata_i <= v;
        @(posedge clk_i);
        wr_i <= 0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [15:0] v);
        @(posedge clk_i);
        rd_i <= 1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 0;
        @(posedge clk_i);
        v = rdata_o;
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 25000; i++) begin
            rd(16'h0112, d);
            if (d[15:14] === 2'b00) return;
        end
        chk(17'h1, 17'h0, "clear timeout");
    endtask
    // Program size code, issue a command and tally both memories
    task automatic run(input logic [2:0] code, input logic [15:0] cmd, input logic [16:0] ec,
        input logic [16:0] es, input logic [15:0] ls);
        wr(16'h0100, {13'h0, code});
        c0 = cn;
        s0 = sn;
        wr(16'h0112, cmd);
        wait_idle();
        chk({3'h0, d[13:0]}, {3'h0, cmd[13:0]}, "cfg readback");
        chk({3'h0, cfg_bits_o}, {3'h0, cmd[13:0]}, "cfg bits");
        chk(cn - c0, ec, "counter words");
        chk(sn - s0, es, "sram words");
        if (ec != 0) chk({1'b0, ca}, 17'h031fe, "counter last");
        if (es != 0) chk({1'b0, sa}, {1'b0, ls}, "sram last");
    endtask
    initial begin
        #2250000;
        bad_count++;
        close_out();
    end
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 0;
        rd(16'h0112, d);
        chk({1'b0, d}, 17'h01000, "config reset");
        rd(16'h0100, d);
        chk({1'b0, d}, 17'h0, "size reset");
        rd(16'h0114, d);
        chk({1'b0, d}, 17'h0, "unmapped read");
        run(3'h0, 16'h4abc, 17'd512, 17'd0, 16'h0);
        run(3'h0, 16'h8123, 17'd0, 17'd1024, 16'h03ff);
        run(3'h1, 16'hd000, 17'd512, 17'd2048, 16'h07ff);
        run(3'h7, 16'h8000, 17'd0, 17'd65536, 16'hffff);
        // Commands wait while main is not held, and a zero write never cancels
        main_held_i <= 0;
        c0 = cn;
        wr(16'h0112, 16'h4000);
        wr(16'h0112, 16'h0000);
        repeat (20) @(posedge clk_i);
        chk(cn - c0, 17'h0, "paused words");
        // A write while the enable is low is ignored
        ce_i <= 0;
        wr(16'h0100, 16'h0005);
        ce_i <= 1;
        rd(16'h0100, d);
        chk({1'b0, d}, 17'h7, "frozen size");
        rd(16'h0112, d);
        chk({16'h0, d[14]}, 17'h1, "pending bit");
        main_held_i <= 1;
        wait_idle();
        chk(cn - c0, 17'd512, "resumed words");
        // Reset in mid wipe returns the register to its reset value
        wr(16'h0112, 16'h8000);
        repeat (10) @(posedge clk_i);
        rst_i <= 1;
        @(posedge clk_i);
        rst_i <= 0;
        rd(16'h0112, d);
        chk({1'b0, d}, 17'h01000, "reset mid wipe");
        close_out();
    end
endmodule // testbench
bind ctinit_top ctinit_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .main_held_i(main_held_i),
    .cnt_we_o(cnt_we_o), .cnt_addr_o(cnt_addr_o), .sram_we_o(sram_we_o),
    .sram_addr_o(sram_addr_o), .cfg_bits_o(cfg_bits_o));
`default_nettype wire
